// [design/dsia_top.sv]
/*
  drive status input assembly: snapshots drive status on a poll request and offers the
  packed produced message to the fieldbus side, plus a small register port and interrupt.
  assumes status inputs are on clk except the terminal levels, which come from pins.
*/
// Design decisions made here: the strobed register port and the register addresses.
// Function
// - layout chosen by selection value 70, 71 or 101
// - basic layout: trip bit 0, forward running bit 2, rest zero
// - trip set while uncleared trip exists; extended four-byte: warning at bit 1
// - forward running flag high only while running forward, bit 2 in basic and extended four-byte, bit 0 in eight-byte
// - extended four-byte: reverse running flag at bit 3
// - extended four-byte: ready bit 4 when state code is 3, 4 or 5
// - extended four-byte: bit 5 shows host run/stop control
// - extended four-byte: bit 6 shows host reference source
// - frequency arrival flag at bit 7 of extended four-byte layout
// - eight-byte byte 0: fwd, rev, trip, arrival, terminals 1..3
// - byte 1 state code, bytes 2-3 frequency low then high
// - eight-byte bytes 4-5 carry output current low then high
// - eight-byte byte 6 trip error code, byte 7 zero
// - state code encoding shared by all layouts
// - state codes: 0 stop through 11 undervoltage, 101-116 tuning
`timescale 1ns/10ps
module dsia_top #(
  parameter int TERM_W = 3
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        trip_active,
  input  wire logic        warn_active,
  input  wire logic        run_fwd,
  input  wire logic        run_rev,
  input  wire logic        net_control,
  input  wire logic        net_reference,
  input  wire logic        freq_arrived,
  input  wire logic [TERM_W-1:0] term_pins,
  input  wire logic [7:0]  drive_state,
  input  wire logic [15:0] freq_monitor,
  input  wire logic [15:0] curr_monitor,
  input  wire logic [7:0]  trip_code,
  input  wire logic        poll_req,
  output logic        msg_valid,
  output logic [63:0] msg_bytes,
  output logic [3:0]  msg_len,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0] reg_rdata,
  output logic        irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    DSIA_IDLE = 2'b01,
    DSIA_PACK = 2'b10
  } dsia_phase_e;

  typedef struct packed {
    dsia_phase_e       phase;
    logic [TERM_W-1:0] t1;
    logic [TERM_W-1:0] t2;
    logic [TERM_W-1:0] t3;
    logic [TERM_W-1:0] term;
    logic              s_trip;
    logic              s_warn;
    logic              s_fwd;
    logic              s_rev;
    logic              s_netc;
    logic              s_netr;
    logic              s_arr;
    logic [TERM_W-1:0] s_term;
    logic [7:0]        s_state;
    logic [15:0]       s_freq;
    logic [15:0]       s_curr;
    logic [7:0]        s_err;
    logic [7:0]        sel;
    logic [7:0]        sel_bad;
    logic              trip_d;
    logic [7:0]        state_d;
    logic [dsia_pkg::IRQ_W-1:0] irq_st;
    logic [dsia_pkg::IRQ_W-1:0] irq_msk;
    logic              valid;
    logic [63:0]       bytes;
    logic [3:0]        len;
    logic [31:0]       rdata;
    logic              irq;
    logic [15:0]       msg_cnt;
  } dsia_state_s;

  dsia_state_s st_r;
  dsia_state_s st_nxt;
  logic [63:0] packed_bytes;
  logic [dsia_pkg::IRQ_W-1:0] ev;

  dsia_snap_if snap ();

  assign snap.trip  = st_r.s_trip;
  assign snap.warn  = st_r.s_warn;
  assign snap.fwd   = st_r.s_fwd && !st_r.s_rev;
  assign snap.rev   = st_r.s_rev && !st_r.s_fwd;
  assign snap.netc  = st_r.s_netc;
  assign snap.netr  = st_r.s_netr;
  assign snap.arr   = st_r.s_arr;
  assign snap.term  = st_r.s_term;
  assign snap.state = st_r.s_state;
  assign snap.freq  = st_r.s_freq;
  assign snap.curr  = st_r.s_curr;
  assign snap.err   = st_r.s_err;

  dsia_pack u_pack (
    .snap    (snap),
    .sel     (st_r.sel),
    .bytes_o (packed_bytes)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // three-stage pin sync; the first stage feeds only the second
    st_nxt.t1 = term_pins;
    st_nxt.t2 = st_r.t1;
    st_nxt.t3 = st_r.t2;
    if (st_r.t2 == st_r.t3) begin
      st_nxt.term = st_r.t3;
    end
    st_nxt.trip_d  = trip_active;
    st_nxt.state_d = drive_state;
    st_nxt.valid   = 1'b0;
    ev = '0;
    ev[dsia_pkg::IRQ_TRIP]  = trip_active && !st_r.trip_d;
    ev[dsia_pkg::IRQ_STATE] = drive_state != st_r.state_d;

    unique case (st_r.phase)
      DSIA_IDLE: begin
        if (poll_req) begin
          // one capture of every field so the host never sees a torn message
          st_nxt.s_trip  = trip_active;
          st_nxt.s_warn  = warn_active;
          st_nxt.s_fwd   = run_fwd;
          st_nxt.s_rev   = run_rev;
          st_nxt.s_netc  = net_control;
          st_nxt.s_netr  = net_reference;
          st_nxt.s_arr   = freq_arrived;
          st_nxt.s_term  = st_r.term;
          st_nxt.s_state = drive_state;
          st_nxt.s_freq  = freq_monitor;
          st_nxt.s_curr  = curr_monitor;
          st_nxt.s_err   = trip_code;
          st_nxt.phase   = DSIA_PACK;
        end
      end
      DSIA_PACK: begin
        st_nxt.bytes = packed_bytes;
        st_nxt.len   = (st_r.sel == dsia_pkg::SEL_EXT8) ? 4'h8 : 4'h4;
        st_nxt.valid = 1'b1;
        st_nxt.msg_cnt = st_r.msg_cnt + 16'h0001;
        ev[dsia_pkg::IRQ_MSG] = 1'b1;
        st_nxt.phase = DSIA_IDLE;
      end
    endcase

    // ----------------------------------------
    // register port
    // ----------------------------------------
    st_nxt.rdata = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        dsia_pkg::REG_CTRL: begin
          // unknown values fall back to the basic layout rather than a blank message
          if (reg_wdata[7:0] == dsia_pkg::SEL_BASIC || reg_wdata[7:0] == dsia_pkg::SEL_EXT4 ||
              reg_wdata[7:0] == dsia_pkg::SEL_EXT8) begin
            st_nxt.sel = reg_wdata[7:0];
          end else begin
            st_nxt.sel     = dsia_pkg::SEL_BASIC;
            st_nxt.sel_bad = reg_wdata[7:0];
          end
        end
        dsia_pkg::REG_IRQMSK: st_nxt.irq_msk = reg_wdata[dsia_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // set wins over write-one-to-clear
    if (reg_wr && reg_addr == dsia_pkg::REG_IRQST) begin
      st_nxt.irq_st = (st_r.irq_st & ~reg_wdata[dsia_pkg::IRQ_W-1:0]) | ev;
    end else begin
      st_nxt.irq_st = st_r.irq_st | ev;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        dsia_pkg::REG_CTRL:   st_nxt.rdata = {16'h0000, st_r.sel_bad, st_r.sel};
        dsia_pkg::REG_STAT:   st_nxt.rdata = {st_r.msg_cnt, 4'h0, st_r.len,
                                              7'h00, st_r.phase == DSIA_PACK};
        dsia_pkg::REG_IRQST:  st_nxt.rdata = {29'h0, st_r.irq_st};
        dsia_pkg::REG_IRQMSK: st_nxt.rdata = {29'h0, st_r.irq_msk};
        dsia_pkg::REG_MSGLO:  st_nxt.rdata = st_r.bytes[31:0];
        dsia_pkg::REG_MSGHI:  st_nxt.rdata = st_r.bytes[63:32];
        dsia_pkg::REG_STCODE: st_nxt.rdata = {24'h000000, st_r.s_state};
        default:              st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_msk);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r         <= '0;
      st_r.phase   <= DSIA_IDLE;
      st_r.sel     <= dsia_pkg::SEL_RESET;
      st_r.irq_msk <= dsia_pkg::IRQMSK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign msg_valid = st_r.valid;
  assign msg_bytes = st_r.bytes;
  assign msg_len   = st_r.len;
  assign reg_rdata = st_r.rdata;
  assign irq       = st_r.irq;
endmodule : dsia_top

// [design/dsia_pkg.sv]
/*
  package for the drive status input assembly: layout selections, byte and bit positions,
  state codes and register map of the plain register port.
  assumes nothing beyond a SystemVerilog compiler.
*/
package dsia_pkg;
  // ----------------------------------------
  // layout selection
  // ----------------------------------------
  localparam logic [7:0] SEL_BASIC     = 8'h46; // 70
  localparam logic [7:0] SEL_EXT4      = 8'h47; // 71
  localparam logic [7:0] SEL_EXT8      = 8'h65; // 101
  localparam logic [7:0] SEL_RESET     = 8'h46;

  // ----------------------------------------
  // byte 0 bit positions
  // ----------------------------------------
  localparam int B70_TRIP  = 0;
  localparam int B70_FWD   = 2;
  localparam int B71_TRIP  = 0;
  localparam int B71_WARN  = 1;
  localparam int B71_FWD   = 2;
  localparam int B71_REV   = 3;
  localparam int B71_READY = 4;
  localparam int B71_NETC  = 5;
  localparam int B71_NETR  = 6;
  localparam int B71_ARR   = 7;
  localparam int B101_FWD  = 0;
  localparam int B101_REV  = 1;
  localparam int B101_TRIP = 2;
  localparam int B101_ARR  = 4;
  localparam int B101_IN1  = 5;

  // ----------------------------------------
  // state codes
  // ----------------------------------------
  localparam logic [7:0] ST_STOP      = 8'h00;
  localparam logic [7:0] ST_RUN       = 8'h01;
  localparam logic [7:0] ST_JOG       = 8'h02;
  localparam logic [7:0] ST_COAST     = 8'h03;
  localparam logic [7:0] ST_DCBRAKE   = 8'h04;
  localparam logic [7:0] ST_RESTART3  = 8'h05;
  localparam logic [7:0] ST_UNDERVOLT = 8'h0b;
  localparam logic [7:0] ST_TUNE_LO   = 8'h65;
  localparam logic [7:0] ST_TUNE_OK   = 8'h73;
  localparam logic [7:0] ST_TUNE_FAIL = 8'h74;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STAT   = 8'h04;
  localparam logic [7:0] REG_IRQST  = 8'h08;
  localparam logic [7:0] REG_IRQMSK = 8'h0c;
  localparam logic [7:0] REG_MSGLO  = 8'h10;
  localparam logic [7:0] REG_MSGHI  = 8'h14;
  localparam logic [7:0] REG_STCODE = 8'h18;

  localparam int IRQ_W       = 3;
  localparam int IRQ_TRIP    = 0;
  localparam int IRQ_STATE   = 1;
  localparam int IRQ_MSG     = 2;
  localparam logic [IRQ_W-1:0] IRQMSK_RESET = 3'h0;

  localparam int MSG_BYTES = 8;
endpackage : dsia_pkg

// [design/dsia_snap_if.sv]
/*
  interface carrying one drive status snapshot from the capture stage to the packer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface dsia_snap_if;
  logic        trip;
  logic        warn;
  logic        fwd;
  logic        rev;
  logic        netc;
  logic        netr;
  logic        arr;
  logic [2:0]  term;
  logic [7:0]  state;
  logic [15:0] freq;
  logic [15:0] curr;
  logic [7:0]  err;
  modport src (output trip, warn, fwd, rev, netc, netr, arr, term, state, freq, curr, err);
  modport dst (input trip, warn, fwd, rev, netc, netr, arr, term, state, freq, curr, err);
endinterface : dsia_snap_if

// [design/dsia_pack.sv]
/*
  packer: builds the eight message bytes from one snapshot for the chosen layout.
  assumes the snapshot stands still while the packed bytes are sampled.
*/
`timescale 1ns/10ps
module dsia_pack (
  dsia_snap_if.dst   snap,
  input  wire logic [7:0]  sel,
  output logic [63:0] bytes_o
);
  logic [7:0] b0;
  logic       ready;

  always_comb begin
    ready = (snap.state == dsia_pkg::ST_COAST) || (snap.state == dsia_pkg::ST_DCBRAKE) ||
            (snap.state == dsia_pkg::ST_RESTART3);
    b0 = 8'h00;
    unique case (sel)
      dsia_pkg::SEL_EXT4: begin
        b0[dsia_pkg::B71_TRIP]  = snap.trip;
        b0[dsia_pkg::B71_WARN]  = snap.warn;
        b0[dsia_pkg::B71_FWD]   = snap.fwd;
        b0[dsia_pkg::B71_REV]   = snap.rev;
        b0[dsia_pkg::B71_READY] = ready;
        b0[dsia_pkg::B71_NETC]  = snap.netc;
        b0[dsia_pkg::B71_NETR]  = snap.netr;
        b0[dsia_pkg::B71_ARR]   = snap.arr;
      end
      dsia_pkg::SEL_EXT8: begin
        b0[dsia_pkg::B101_FWD]  = snap.fwd;
        b0[dsia_pkg::B101_REV]  = snap.rev;
        b0[dsia_pkg::B101_TRIP] = snap.trip;
        b0[dsia_pkg::B101_ARR]  = snap.arr;
        b0[dsia_pkg::B101_IN1 +: 3] = snap.term;
      end
      default: begin
        b0[dsia_pkg::B70_TRIP] = snap.trip;
        b0[dsia_pkg::B70_FWD]  = snap.fwd;
      end
    endcase
    // bytes 4..7 zero outside the long layout
    if (sel == dsia_pkg::SEL_EXT8) begin
      bytes_o = {8'h00, snap.err, snap.curr[15:8], snap.curr[7:0],
                 snap.freq[15:8], snap.freq[7:0], snap.state, b0};
    end else begin
      bytes_o = {32'h0000_0000, snap.freq[15:8], snap.freq[7:0], snap.state, b0};
    end
  end
endmodule : dsia_pack

// [tb/dsia_assertions.sv]
/* checker for dsia_top: message timing and field placement.
   assumes a bind to dsia_top and one clock. */
`timescale 1ns/10ps
module dsia_assertions (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        run_fwd,
  input wire logic        run_rev,
  input wire logic [7:0]  drive_state,
  input wire logic [15:0] freq_monitor,
  input wire logic [15:0] curr_monitor,
  input wire logic [7:0]  trip_code,
  input wire logic        poll_req,
  input wire logic        msg_valid,
  input wire logic [63:0] msg_bytes,
  input wire logic [3:0]  msg_len
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // three quiet cycles guarantee the packer is idle
  sequence idle_poll; !poll_req [*3] ##1 poll_req; endsequence
  // the pack cycle sits between the taking edge and the answer, so fields are two edges old
  sequence answer; !msg_valid ##1 msg_valid; endsequence
  poll_answer_a: assert property (idle_poll |=> answer)
    else $error("poll not answered on time");
  valid_pulse_a: assert property (msg_valid |=> !msg_valid)
    else $error("valid longer than one cycle");
  len_legal_a: assert property (msg_valid |-> msg_len == 4'h4 || msg_len == 4'h8)
    else $error("bad message length");
  state_byte_a: assert property (msg_valid |-> msg_bytes[15:8] == $past(drive_state, 2))
    else $error("state byte wrong");
  freq_bytes_a: assert property (msg_valid |-> msg_bytes[31:16] == $past(freq_monitor, 2))
    else $error("frequency bytes wrong");
  curr_bytes_a: assert property (msg_valid && msg_len == 4'h8 |->
    msg_bytes[47:32] == $past(curr_monitor, 2))
    else $error("current bytes wrong");
  code_byte_a: assert property (msg_valid && msg_len == 4'h8 |->
    msg_bytes[63:48] == {8'h00, $past(trip_code, 2)})
    else $error("trip code bytes wrong");
  short_zero_a: assert property (msg_valid && msg_len == 4'h4 |-> msg_bytes[63:32] == 32'h0)
    else $error("short layout upper bytes not zero");
  fwd_flag_a: assert property (msg_valid && msg_len == 4'h8 |->
    msg_bytes[0] == ($past(run_fwd, 2) && !$past(run_rev, 2)))
    else $error("forward flag wrong");
endmodule : dsia_assertions

// [tb/dsia_host_model.sv]
/* host model: polls the block and captures the produced message.
   assumes the message answers within six cycles. */
`timescale 1ns/10ps
module dsia_host_model (
  input  wire logic        clk,
  output logic             poll_req,
  input  wire logic        msg_valid,
  input  wire logic [63:0] msg_bytes,
  input  wire logic [3:0]  msg_len
);
  // ----------------------------------------
  // poll task
  // ----------------------------------------
  logic [63:0] got_bytes;
  logic [3:0]  got_len;
  logic        got_ok;
  initial poll_req = 1'b0;
  // gap models a slow host that waits before asking
  task automatic poll(input int gap);
    got_ok = 1'b0;
    repeat (gap) @(posedge clk);
    poll_req <= 1'b1;
    @(posedge clk);
    poll_req <= 1'b0;
    for (int i = 0; i < 6 && !got_ok; i++) begin
      // sample away from the edge that launches the answer
      @(negedge clk);
      if (msg_valid === 1'b1) begin
        got_ok = 1'b1;
        got_bytes = msg_bytes;
        got_len = msg_len;
      end
    end
    // hand back on a rising edge so the caller keeps driving by non-blocking assignment
    @(posedge clk);
  endtask : poll
endmodule : dsia_host_model

// [tb/testbench.sv]
/* testbench for dsia_top: layouts, fields, registers, interrupt.
   assumes checker and host model are compiled first. */
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic        clk = 1'b0, reset = 1'b1, msg_valid, irq, reg_wr = 1'b0, reg_rd = 1'b0, poll_req;
  logic        trip_active = 1'b0, warn_active = 1'b0, run_fwd = 1'b0, run_rev = 1'b0;
  logic        net_control = 1'b0, net_reference = 1'b0, freq_arrived = 1'b0;
  logic [2:0]  term_pins = 3'h0;
  logic [7:0]  drive_state = 8'h00, trip_code = 8'h00, reg_addr = 8'h00, sel = dsia_pkg::SEL_BASIC;
  logic [15:0] freq_monitor = 16'h0000, curr_monitor = 16'h0000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_data;
  logic [63:0] msg_bytes;
  logic [3:0]  msg_len;
  int          mismatches = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  dsia_top dsia_top_i (.clk, .reset, .trip_active, .warn_active, .run_fwd, .run_rev, .net_control,
    .net_reference, .freq_arrived, .term_pins, .drive_state, .freq_monitor, .curr_monitor, .trip_code,
    .poll_req, .msg_valid, .msg_bytes, .msg_len, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  dsia_host_model dsia_host_model_i (.clk, .poll_req, .msg_valid, .msg_bytes, .msg_len);
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_data = reg_rdata;
  endtask : rd
  function automatic logic [63:0] exp_msg(input logic [7:0] s);
    logic f, r, rdy;
    f = run_fwd & ~run_rev;
    r = run_rev & ~run_fwd;
    rdy = drive_state inside {8'h03, 8'h04, 8'h05};
    exp_msg = {32'h0, freq_monitor, drive_state, 8'h00};
    if (s == dsia_pkg::SEL_BASIC)
      exp_msg[7:0] = {5'h0, f, 1'b0, trip_active};
    else if (s == dsia_pkg::SEL_EXT4)
      exp_msg[7:0] = {freq_arrived, net_reference, net_control, rdy, r, f, warn_active, trip_active};
    else
      exp_msg = {8'h00, trip_code, curr_monitor, freq_monitor, drive_state, term_pins, freq_arrived, 1'b0,
        trip_active, r, f};
  endfunction : exp_msg
  task automatic poll_chk(input int gap);
    dsia_host_model_i.poll(gap);
    chk("answered", {63'h0, dsia_host_model_i.got_ok}, 64'h1);
    chk("bytes", dsia_host_model_i.got_bytes, exp_msg(sel));
    chk("length", {60'h0, dsia_host_model_i.got_len}, (sel == dsia_pkg::SEL_EXT8) ? 64'h8 : 64'h4);
  endtask : poll_chk
  task automatic set_layout(input logic [7:0] s);
    wr(dsia_pkg::REG_CTRL, {24'h0, s});
    sel = s;
  endtask : set_layout
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_basic();
    @(posedge clk);
    trip_active <= 1'b1;
    warn_active <= 1'b1;
    run_fwd <= 1'b1;
    freq_monitor <= 16'h1234;
    drive_state <= dsia_pkg::ST_RUN;
    poll_chk(2);
    run_rev <= 1'b1;
    poll_chk(0);
    trip_active <= 1'b0;
    poll_chk(5);
  endtask : s_basic
  task automatic s_ext4();
    logic [7:0] codes [7] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0b, dsia_pkg::ST_TUNE_OK};
    set_layout(dsia_pkg::SEL_EXT4);
    foreach (codes[i]) begin
      @(posedge clk);
      drive_state <= codes[i];
      {freq_arrived, net_reference, net_control, run_rev, run_fwd, warn_active, trip_active} <= 7'(i * 43);
      poll_chk(1);
    end
  endtask : s_ext4
  task automatic s_ext8();
    set_layout(dsia_pkg::SEL_EXT8);
    @(posedge clk);
    term_pins <= 3'h5;
    curr_monitor <= 16'hbeef;
    trip_code <= 8'h3c;
    repeat (6) @(posedge clk);
    poll_chk(0);
    term_pins <= 3'h2;
    repeat (6) @(posedge clk);
    poll_chk(0);
  endtask : s_ext8
  task automatic s_regs();
    logic [63:0] e;
    e = exp_msg(sel);
    rd(dsia_pkg::REG_MSGLO);
    chk("last low word", {32'h0, rd_data}, {32'h0, e[31:0]});
    rd(8'hfc);
    chk("unmapped read", {32'h0, rd_data}, 64'h0);
    wr(dsia_pkg::REG_IRQST, 32'h7);
    wr(dsia_pkg::REG_IRQMSK, 32'h4);
    poll_chk(1);
    // look at the level between edges, never in the step that updates it
    repeat (2) @(negedge clk);
    chk("irq raised", {63'h0, irq}, 64'h1);
    rd(dsia_pkg::REG_IRQST);
    chk("status bit", {63'h0, rd_data[dsia_pkg::IRQ_MSG]}, 64'h1);
    wr(dsia_pkg::REG_IRQST, 32'h4);
    repeat (2) @(negedge clk);
    chk("irq cleared", {63'h0, irq}, 64'h0);
    wr(dsia_pkg::REG_IRQMSK, 32'h0);
    poll_chk(1);
    repeat (2) @(negedge clk);
    chk("irq masked", {63'h0, irq}, 64'h0);
  endtask : s_regs
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("reset outputs", {57'h0, msg_valid, irq, msg_len, reg_rdata[0]}, 64'h0);
    s_basic();
    s_ext4();
    s_ext8();
    s_regs();
    complete_run();
  end
  // a hang never reaches the end of the sequence above
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule : testbench
bind dsia_top dsia_assertions dsia_assertions_i (.clk, .reset, .run_fwd, .run_rev, .drive_state, .freq_monitor,
  .curr_monitor, .trip_code, .poll_req, .msg_valid, .msg_bytes, .msg_len);
